//--- hw/sae_defines.svh
// Purpose: constants for the store/add/subtract/and execution block
// Assumes: 25 MHz mclk, one machine cycle = three clock periods
// Notes: definitions only
`ifndef SAE_DEFINES_SVH
`define SAE_DEFINES_SVH
`define SAE_CLK_NS 40
`define SAE_CYCLE_NS 120
`define SAE_PER_CYC 3
`define SAE_CYC_DIV_W 2
`define SAE_COND_POS 2'h1
`define SAE_COND_ZERO 2'h0
`define SAE_COND_NEG 2'h2
`define SAE_OP_NOP 8'hc0
`define SAE_OP_HALT 8'h40
`define SAE_GRP_AND 3'h2
`define SAE_GRP_ADD 3'h4
`define SAE_GRP_SUB 3'h5
`define SAE_GRP_STR 3'h6
`define SAE_MODE_Z 2'h0
`define SAE_MODE_I 2'h1
`define SAE_MODE_R 2'h2
`define SAE_MODE_A 2'h3
`define SAE_IDX_NONE 2'h0
`define SAE_IDX_INC 2'h1
`define SAE_IDX_DEC 2'h2
`define SAE_IDX_ONLY 2'h3
`define SAE_IND_BIT 7
`define SAE_CYC_ZI 3'h2
`define SAE_CYC_R 3'h3
`define SAE_CYC_A 3'h4
`define SAE_CYC_IND 3'h2
`endif

//--- hw/sae_pkg.sv
// Purpose: shared types for the execution block
// Assumes: nothing
// Notes: constants live in sae_defines.svh
package sae_pkg;
    typedef enum logic [2:0] {
        SAE_IDLE = 3'b000,
        SAE_FETCH = 3'b001,
        SAE_IND = 3'b010,
        SAE_EXEC = 3'b011,
        SAE_WAIT = 3'b100,
        SAE_HALTED = 3'b101
    } sae_state_e;
    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic dcy;
        logic oflow;
        logic [1:0] cond;
    } sae_alu_s;
    typedef struct packed {
        logic req;
        logic wr;
        logic [14:0] addr;
        logic [7:0] wdata;
    } sae_mem_s;
endpackage

//--- hw/sae_ccgen.sv
// Purpose: condition code from a result byte
// Assumes: combinational
// Notes: zero wins over sign, which cannot both hold anyway
`timescale 1ns/100ps
`default_nettype none
`include "sae_defines.svh"
module sae_ccgen (
    input wire logic [7:0] val,
    output logic [1:0] cond
);
    assign cond = (val == 8'h00) ? `SAE_COND_ZERO : (val[7] ? `SAE_COND_NEG : `SAE_COND_POS);
endmodule
`default_nettype wire

//--- hw/sae_alu.sv
// Purpose: binary adder, subtract by two's complement, bitwise and
// Assumes: carry mode input chooses whether carry/borrow joins the sum
// Notes: borrow is the inverted carry, so subtract with borrow adds c_in
`timescale 1ns/100ps
`default_nettype none
`include "sae_defines.svh"
module sae_alu (
    input wire logic [2:0] grp,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic c_in,
    input wire logic with_carry,
    output sae_pkg::sae_alu_s out
);
    wire logic is_sub = (grp == `SAE_GRP_SUB);
    wire logic [7:0] b_op = is_sub ? (~b) : b;
    wire logic cin = with_carry ? c_in : is_sub;
    wire logic [8:0] sum = {1'b0, a} + {1'b0, b_op} + {8'h00, cin};
    wire logic [4:0] low = {1'b0, a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
    wire logic [7:0] andv = a & b;
    wire logic is_and = (grp == `SAE_GRP_AND);
    wire logic [7:0] res = is_and ? andv : sum[7:0];
    wire logic [1:0] cond;
    sae_ccgen u_cond (.val(res), .cond(cond));
    assign out.res = res;
    assign out.c = sum[8];
    assign out.dcy = low[4];
    assign out.oflow = (a[7] == b_op[7]) && (sum[7] != a[7]);
    assign out.cond = cond;
endmodule
`default_nettype wire

//--- hw/sae_exec.sv
// Purpose: executes store, add, subtract and and instruction groups
// Assumes: memory answers mem_ack after any number of cycles; operands arrive as bytes
// Notes: memory inputs are same-clock logic, no synchronisers
`timescale 1ns/100ps
`default_nettype none
`include "sae_defines.svh"
module sae_exec #(
    parameter int PER_CYC = `SAE_PER_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [7:0] op,
    input wire logic [7:0] byte1,
    input wire logic [7:0] byte2,
    input wire logic [14:0] next_pc,
    input wire logic with_carry,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic busy,
    output logic done,
    output logic halted,
    output logic mem_req,
    output logic mem_wr,
    output logic [14:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic [7:0] reg0,
    output logic [7:0] reg1,
    output logic [7:0] reg2,
    output logic [7:0] reg3,
    output logic [1:0] condition_code,
    output logic carry,
    output logic interdigit_carry,
    output logic overflow_flag
);
    // ---------------------------------------------------------------
    // machine cycle enable
    // ---------------------------------------------------------------
    logic [`SAE_CYC_DIV_W-1:0] div_r;
    wire logic cyc_en = (div_r == `SAE_CYC_DIV_W'(PER_CYC - 1));
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            div_r <= '0;
        else
            div_r <= cyc_en ? '0 : div_r + 1'b1;
    end

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    sae_pkg::sae_state_e st_r;
    logic [7:0] op_r, b1_r, b2_r, mdata_r;
    logic [14:0] pc_r, ea_r;
    logic [2:0] left_r;
    logic [7:0] regs_r [4];
    logic [1:0] cond_r;
    logic c_r, dcy_r, oflow_r;
    sae_pkg::sae_mem_s mem_r;
    logic done_r;

    wire logic [2:0] grp = op_r[7:5];
    wire logic [1:0] mode = op_r[3:2];
    wire logic [1:0] rsel = op_r[1:0];
    wire logic [1:0] idxc = b1_r[6:5];
    wire logic is_abs = (mode == `SAE_MODE_A);
    wire logic is_rel = (mode == `SAE_MODE_R);
    wire logic is_mem = is_abs || is_rel;
    wire logic indir = is_mem && b1_r[`SAE_IND_BIT];
    wire logic indexed = is_abs && (idxc != `SAE_IDX_NONE);
    wire logic [1:0] dst = (mode == `SAE_MODE_Z || indexed) ? 2'h0 : rsel;
    wire logic [7:0] idx_adj = (idxc == `SAE_IDX_INC) ? regs_r[rsel] + 8'h01 :
                               (idxc == `SAE_IDX_DEC) ? regs_r[rsel] - 8'h01 : regs_r[rsel];
    wire logic [14:0] rel_ea = pc_r + {{8{b1_r[6]}}, b1_r[6:0]};
    wire logic [14:0] abs_base = {pc_r[14:13], b1_r[4:0], b2_r};
    wire logic [14:0] pre_ea = is_rel ? rel_ea : abs_base;
    // index register was already stepped in fetch, so add it as it stands
    wire logic [14:0] idx_ea = ea_r + (indexed ? {7'h00, regs_r[rsel]} : 15'h0000);
    wire logic is_nop = (op_r == `SAE_OP_NOP);
    wire logic is_halt = (op_r == `SAE_OP_HALT);
    wire logic [2:0] base_cyc = is_abs ? `SAE_CYC_A : (is_rel ? `SAE_CYC_R : `SAE_CYC_ZI);
    wire logic [2:0] tot_cyc = base_cyc + (indir ? `SAE_CYC_IND : 3'h0);
    // operand a is the destination; b is r, immediate or memory
    wire logic [7:0] opnd_a = (mode == `SAE_MODE_Z) ? regs_r[0] : regs_r[dst];
    wire logic [7:0] opnd_b = (mode == `SAE_MODE_Z) ? regs_r[rsel] :
                              (mode == `SAE_MODE_I) ? b1_r : mdata_r;
    sae_pkg::sae_alu_s alu;
    sae_alu u_alu (.grp(grp), .a(opnd_a), .b(opnd_b), .c_in(c_r),
                   .with_carry(with_carry), .out(alu));
    wire logic [1:0] st_cond;
    sae_ccgen u_stcc (.val(regs_r[0]), .cond(st_cond));
    wire logic is_store = (grp == `SAE_GRP_STR);
    wire logic is_arith = (grp == `SAE_GRP_ADD) || (grp == `SAE_GRP_SUB);

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= sae_pkg::SAE_IDLE;
            op_r <= 8'h00;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            pc_r <= 15'h0000;
            ea_r <= 15'h0000;
            mdata_r <= 8'h00;
            left_r <= 3'h0;
            for (int i = 0; i < 4; i++)
                regs_r[i] <= 8'h00;
            cond_r <= `SAE_COND_ZERO;
            c_r <= 1'b0;
            dcy_r <= 1'b0;
            oflow_r <= 1'b0;
            mem_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            case (st_r)
                sae_pkg::SAE_IDLE:
                begin
                    if (start)
                    begin
                        op_r <= op;
                        b1_r <= byte1;
                        b2_r <= byte2;
                        pc_r <= next_pc;
                        st_r <= sae_pkg::SAE_FETCH;
                    end
                end
                sae_pkg::SAE_FETCH:
                begin
                    left_r <= tot_cyc - 3'h1;
                    ea_r <= pre_ea;
                    if (indexed && idxc != `SAE_IDX_ONLY)
                        regs_r[rsel] <= idx_adj;
                    if (is_halt)
                        st_r <= sae_pkg::SAE_HALTED;
                    else if (indir)
                    begin
                        mem_r <= '{req: 1'b1, wr: 1'b0, addr: pre_ea, wdata: 8'h00};
                        st_r <= sae_pkg::SAE_IND;
                    end
                    else
                        st_r <= sae_pkg::SAE_WAIT;
                end
                sae_pkg::SAE_IND:
                begin
                    if (mem_ack)
                    begin
                        // high byte first, top bit ignored
                        if (mem_r.addr == ea_r)
                        begin
                            mdata_r <= mem_rdata;
                            mem_r.addr <= ea_r + 15'h0001;
                        end
                        else
                        begin
                            ea_r <= {mdata_r[6:0], mem_rdata};
                            mem_r.req <= 1'b0;
                            st_r <= sae_pkg::SAE_WAIT;
                        end
                    end
                end
                sae_pkg::SAE_WAIT:
                begin
                    if (cyc_en)
                    begin
                        if (left_r == 3'h1)
                        begin
                            if (is_mem)
                                mem_r <= '{req: 1'b1, wr: is_store, addr: idx_ea,
                                           wdata: regs_r[indexed ? 2'h0 : rsel]};
                            st_r <= sae_pkg::SAE_EXEC;
                        end
                        else
                            left_r <= left_r - 3'h1;
                    end
                end
                sae_pkg::SAE_EXEC:
                begin
                    if (!is_mem || mem_ack)
                    begin
                        mem_r.req <= 1'b0;
                        if (is_mem && !is_store)
                            mdata_r <= mem_rdata;
                        if (is_mem && !is_store)
                            st_r <= sae_pkg::SAE_HALTED; // retire next edge via ALU on latched data
                        else
                        begin
                            if (is_store && mode == `SAE_MODE_Z && !is_nop)
                            begin
                                regs_r[rsel] <= regs_r[0];
                                cond_r <= st_cond;
                            end
                            else if (!is_store)
                            begin
                                regs_r[dst] <= alu.res;
                                cond_r <= alu.cond;
                                if (is_arith)
                                begin
                                    c_r <= alu.c;
                                    dcy_r <= alu.dcy;
                                    oflow_r <= alu.oflow;
                                end
                            end
                            done_r <= 1'b1;
                            st_r <= sae_pkg::SAE_IDLE;
                        end
                    end
                end
                sae_pkg::SAE_HALTED:
                begin
                    // doubles as the write-back step for memory operands
                    if (!is_halt)
                    begin
                        regs_r[dst] <= alu.res;
                        cond_r <= alu.cond;
                        if (is_arith)
                        begin
                            c_r <= alu.c;
                            dcy_r <= alu.dcy;
                            oflow_r <= alu.oflow;
                        end
                        done_r <= 1'b1;
                        st_r <= sae_pkg::SAE_IDLE;
                    end
                end
                default: st_r <= sae_pkg::SAE_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            halted <= 1'b0;
        end
        else
        begin
            busy <= (st_r != sae_pkg::SAE_IDLE) && !(st_r == sae_pkg::SAE_HALTED && is_halt);
            halted <= (st_r == sae_pkg::SAE_HALTED) && is_halt;
        end
    end
    assign done = done_r;
    assign mem_req = mem_r.req;
    assign mem_wr = mem_r.wr;
    assign mem_addr = mem_r.addr;
    assign mem_wdata = mem_r.wdata;
    assign reg0 = regs_r[0];
    assign reg1 = regs_r[1];
    assign reg2 = regs_r[2];
    assign reg3 = regs_r[3];
    assign condition_code = cond_r;
    assign carry = c_r;
    assign interdigit_carry = dcy_r;
    assign overflow_flag = oflow_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_store_done;
        done && is_store && is_mem;
    endsequence
    store_no_flags_a: assert property (s_store_done |-> $stable(cond_r) && $stable(c_r))
        else $error("store changed flags");
    nop_keeps_regs_a: assert property (done && is_nop |-> $stable(regs_r[0]) && $stable(cond_r))
        else $error("nop changed state");
    halt_entered_a: assert property ((st_r == sae_pkg::SAE_FETCH) && is_halt |=> halted || st_r == sae_pkg::SAE_HALTED)
        else $error("halt not taken");
    cond_code_a: assert property (done && !is_store |-> cond_r != 2'h3)
        else $error("illegal condition code");
    cond_zero_a: assert property (done && !is_store && regs_r[dst] == 8'h00 |-> cond_r == `SAE_COND_ZERO)
        else $error("zero result gave nonzero condition code");
    cond_neg_a: assert property (done && !is_store && regs_r[dst][7] |-> cond_r == `SAE_COND_NEG)
        else $error("negative result condition code wrong");
    store_write_a: assert property (st_r == sae_pkg::SAE_EXEC && is_store && is_mem |-> mem_wr && mem_req)
        else $error("store without write");
    ind_addr_a: assert property (st_r == sae_pkg::SAE_IND |-> mem_req && !mem_wr)
        else $error("indirect fetch not a read");
    busy_bound_a: assert property ($rose(busy) |-> ##[1:40] !busy || halted)
        else $error("instruction never finished");
endmodule
`default_nettype wire

//--- sim/sae_mem_model.sv
// Purpose: byte-wide memory standing at the far side of the execution block
// Assumes: one request held until mem_ack; ack is a one-cycle pulse
// Notes: lat adds wait cycles; read data churns while no request is answered
`timescale 1ns/100ps
`default_nettype none
module sae_mem_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic mem_req,
    input wire logic mem_wr,
    input wire logic [14:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    // ----------------------------------------
    // storage and write log
    // ----------------------------------------
    logic [7:0] mem_a [0:32767];
    int lat = 0;
    int cnt_r;
    logic [14:0] wr_addr = 15'h0000;
    logic [7:0] wr_data = 8'h00;
    // ----------------------------------------
    // answer
    // ----------------------------------------
    // ack never stays high two cycles, so a held request is not answered twice
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_ack <= 1'b0;
            cnt_r <= 0;
            mem_rdata <= 8'h5a;
        end
        else if (mem_req && !mem_ack && cnt_r < lat)
        begin
            cnt_r <= cnt_r + 1;
            mem_rdata <= ~mem_rdata;
        end
        else if (mem_req && !mem_ack)
        begin
            mem_ack <= 1'b1;
            cnt_r <= 0;
            if (mem_wr)
            begin
                mem_a[mem_addr] <= mem_wdata;
                wr_addr <= mem_addr;
                wr_data <= mem_wdata;
            end
            else
                mem_rdata <= mem_a[mem_addr];
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Purpose: self-checking bench for the execution block
// Assumes: timing is approximate, so cycle counts are compared by order only
// Notes: registers are seeded through add immediate, as there is no register load port
`timescale 1ns/100ps
`default_nettype none
`include "sae_defines.svh"
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] op = 8'h00;
    logic [7:0] byte1 = 8'h00;
    logic [7:0] byte2 = 8'h00;
    logic [14:0] next_pc = 15'h0000;
    logic with_carry = 1'b0;
    logic [7:0] mem_rdata;
    logic mem_ack, busy, done, halted, mem_req, mem_wr;
    logic [14:0] mem_addr;
    logic [7:0] mem_wdata, reg0, reg1, reg2, reg3;
    logic [1:0] condition_code;
    logic carry, interdigit_carry, overflow_flag;
    logic [7:0] m_r [4];
    logic m_c, m_dcy, m_oflow;
    logic [1:0] m_cond;
    int err_count = 0;
    int check_count = 0;
    int cyc_cnt = 0;
    int cyc, cz, cr, ca, ci;
    always #20 mclk = ~mclk;
    sae_exec #(.PER_CYC(3)) dut (.mclk(mclk), .arst_n(arst_n), .start(start), .op(op), .byte1(byte1),
        .byte2(byte2), .next_pc(next_pc), .with_carry(with_carry), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .busy(busy), .done(done), .halted(halted), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .reg0(reg0), .reg1(reg1), .reg2(reg2), .reg3(reg3),
        .condition_code(condition_code), .carry(carry), .interdigit_carry(interdigit_carry),
        .overflow_flag(overflow_flag));
    sae_mem_model mem (.mclk(mclk), .arst_n(arst_n), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] opc(input logic [2:0] g, input logic [1:0] m, input logic [1:0] r);
        opc = {g, 1'b0, m, r};
    endfunction
    function automatic logic [1:0] ccof(input logic [7:0] v);
        ccof = (v == 8'h00) ? `SAE_COND_ZERO : (v[7] ? `SAE_COND_NEG : `SAE_COND_POS);
    endfunction
    task automatic arith(input int dst, input logic [7:0] a, input logic [7:0] b, input logic sub);
        logic [7:0] bb;
        logic cin;
        logic [8:0] s;
        bb = sub ? ~b : b;
        cin = with_carry ? m_c : sub;
        s = a + bb + cin;
        m_dcy = ({1'b0, a[3:0]} + bb[3:0] + cin) > 5'h0f;
        m_oflow = (a[7] == bb[7]) && (s[7] != a[7]);
        m_c = s[8];
        m_r[dst] = s[7:0];
        m_cond = ccof(s[7:0]);
    endtask
    task automatic chk(input logic [36:0] got, input logic [36:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic state;
        chk({reg0, reg1, reg2, reg3, condition_code, carry, interdigit_carry, overflow_flag},
            {m_r[0], m_r[1], m_r[2], m_r[3], m_cond, m_c, m_dcy, m_oflow});
    endtask
    task automatic drive(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2, input logic [14:0] pc);
        @(posedge mclk);
        #1;
        op = o;
        byte1 = b1;
        byte2 = b2;
        next_pc = pc;
        start = 1'b1;
        @(posedge mclk);
        #1;
        start = 1'b0;
    endtask
    // waits for the retire pulse under a bound; cyc counts edges from the take
    task automatic run(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2, input logic [14:0] pc);
        drive(o, b1, b2, pc);
        cyc = 1;
        while (done !== 1'b1 && cyc < 300)
        begin
            @(posedge mclk);
            #1;
            cyc++;
        end
        chk(done, 1'b1);
    endtask
    task automatic do_reset;
        arst_n = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        for (int i = 0; i < 4; i++)
            m_r[i] = 8'h00;
        {m_c, m_dcy, m_oflow, m_cond} = 5'h00;
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        do_reset();
        state();
        chk({busy, halted, mem_req, done}, 4'h0);
        run(opc(`SAE_GRP_ADD, `SAE_MODE_I, 0), 8'h7f, 8'h00, 15'h0000);
        arith(0, m_r[0], 8'h7f, 1'b0);
        state();
        run(opc(`SAE_GRP_ADD, `SAE_MODE_I, 2), 8'h80, 8'h00, 15'h0000);
        arith(2, m_r[2], 8'h80, 1'b0);
        state();
        run(opc(`SAE_GRP_ADD, `SAE_MODE_I, 3), 8'h00, 8'h00, 15'h0000);
        arith(3, m_r[3], 8'h00, 1'b0);
        state();
        $display("test immediates done");
        run(opc(`SAE_GRP_STR, `SAE_MODE_Z, 1), 8'h00, 8'h00, 15'h0000);
        m_r[1] = m_r[0];
        m_cond = ccof(m_r[0]);
        state();
        run(`SAE_OP_NOP, 8'h00, 8'h00, 15'h0000);
        state();
        run(opc(`SAE_GRP_ADD, `SAE_MODE_Z, 2), 8'h00, 8'h00, 15'h0000);
        cz = cyc;
        arith(0, m_r[0], m_r[2], 1'b0);
        state();
        run(opc(`SAE_GRP_ADD, `SAE_MODE_I, 0), 8'h01, 8'h00, 15'h0000);
        arith(0, m_r[0], 8'h01, 1'b0);
        state();
        with_carry = 1'b1;
        run(opc(`SAE_GRP_ADD, `SAE_MODE_I, 1), 8'h00, 8'h00, 15'h0000);
        arith(1, m_r[1], 8'h00, 1'b0);
        state();
        with_carry = 1'b0;
        run(opc(`SAE_GRP_SUB, `SAE_MODE_I, 1), 8'h01, 8'h00, 15'h0000);
        arith(1, m_r[1], 8'h01, 1'b1);
        state();
        run(opc(`SAE_GRP_SUB, `SAE_MODE_Z, 1), 8'h00, 8'h00, 15'h0000);
        arith(0, m_r[0], m_r[1], 1'b1);
        state();
        with_carry = 1'b1;
        run(opc(`SAE_GRP_SUB, `SAE_MODE_I, 0), 8'h01, 8'h00, 15'h0000);
        arith(0, m_r[0], 8'h01, 1'b1);
        state();
        with_carry = 1'b0;
        run(opc(`SAE_GRP_AND, `SAE_MODE_Z, 2), 8'h00, 8'h00, 15'h0000);
        m_r[0] = m_r[0] & m_r[2];
        m_cond = ccof(m_r[0]);
        state();
        $display("test register forms done");
        run(opc(`SAE_GRP_STR, `SAE_MODE_R, 1), 8'h7e, 8'h00, 15'h0100);
        chk({mem.wr_addr, mem.wr_data}, {15'h00fe, m_r[1]});
        state();
        run(opc(`SAE_GRP_STR, `SAE_MODE_A, 2), 8'h05, 8'h34, 15'h4010);
        chk({mem.wr_addr, mem.wr_data}, {15'h4534, m_r[2]});
        state();
        run(opc(`SAE_GRP_ADD, `SAE_MODE_I, 1), 8'h10 - m_r[1], 8'h00, 15'h0000);
        arith(1, m_r[1], 8'h10 - m_r[1], 1'b0);
        for (int ic = 1; ic < 4; ic++)
        begin
            run(opc(`SAE_GRP_STR, `SAE_MODE_A, 1), {1'b0, ic[1:0], 5'h00}, 8'h20, 15'h0003);
            if (ic == 1)
                m_r[1] = m_r[1] + 8'h01;
            else if (ic == 2)
                m_r[1] = m_r[1] - 8'h01;
            chk({mem.wr_addr, mem.wr_data}, {15'h0020 + m_r[1], m_r[0]});
            state();
        end
        $display("test stores done");
        mem.mem_a[15'h0205] = 8'h3c;
        mem.mem_a[15'h2140] = 8'h9a;
        mem.mem_a[15'h0303] = 8'h81;
        mem.mem_a[15'h0304] = 8'h50;
        mem.mem_a[15'h0150] = 8'h22;
        mem.mem_a[15'h0060] = 8'h11;
        run(opc(`SAE_GRP_ADD, `SAE_MODE_R, 2), 8'h05, 8'h00, 15'h0200);
        cr = cyc;
        arith(2, m_r[2], 8'h3c, 1'b0);
        state();
        run(opc(`SAE_GRP_SUB, `SAE_MODE_A, 3), 8'h01, 8'h40, 15'h2000);
        ca = cyc;
        arith(3, m_r[3], 8'h9a, 1'b1);
        state();
        run(opc(`SAE_GRP_ADD, `SAE_MODE_R, 3), 8'h83, 8'h00, 15'h0300);
        ci = cyc;
        arith(3, m_r[3], 8'h22, 1'b0);
        state();
        chk({cr > cz, ca > cr, ci > cr}, 3'h7);
        mem.lat = 2;
        run(opc(`SAE_GRP_SUB, `SAE_MODE_A, 1), 8'h60, 8'h50, 15'h0000);
        arith(0, m_r[0], 8'h11, 1'b1);
        state();
        $display("test memory operands done");
        drive(`SAE_OP_HALT, 8'h00, 8'h00, 15'h0000);
        repeat (12) @(posedge mclk);
        #1;
        chk(halted, 1'b1);
        drive(opc(`SAE_GRP_ADD, `SAE_MODE_I, 0), 8'h01, 8'h00, 15'h0000);
        repeat (20) @(posedge mclk);
        #1;
        state();
        do_reset();
        chk({halted, busy}, 2'h0);
        state();
        $display("test halt done");
        wrap_up();
    end
endmodule
`default_nettype wire
